/* File: core/wdu_pkg.sv */
// watchdog timeout unit: shared constants and types
package wdu_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] RESTART_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
  // control register field positions
  localparam int EN_BIT = 7;
  localparam int NMI_SEL_BIT = 6;
  localparam int CAUSE_BIT = 5;
  localparam int CLK_SEL_LO = 3;
  localparam int PERIOD_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // restart keys
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'h5a;
  // clock select codes
  localparam logic [1:0] CLK_SYS = 2'h0;
  localparam logic [1:0] CLK_RTC = 2'h1;
  // counter reload values; each timeout lasts one tick more than its value
  localparam int CNT_W = 27;
  localparam logic [CNT_W-1:0] PERIOD_00 = 27'h7ffffff;
  localparam logic [CNT_W-1:0] PERIOD_01 = 27'h1ffffff;
  localparam logic [CNT_W-1:0] PERIOD_10 = 27'h03fffff;
  localparam logic [CNT_W-1:0] PERIOD_11 = 27'h003ffff;
  // interrupt status bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_RESTART = 1;
  localparam int SYNC_DEPTH = 3;
  typedef enum logic [1:0] {
    wdu_key_idle = 2'b00,
    wdu_key_armed = 2'b01
  } wdu_key_t;
endpackage

/* File: core/wdu_tick_if.sv */
// tick and restart signals between watchdog top and counter
`timescale 1ns/10ps
interface wdu_tick_if;
  logic       tick;
  logic       restart;
  logic       run;
  logic [1:0] period;
  logic       expire;
  modport ctrl (output tick, output restart, output run, output period,
                input expire);
  modport cnt  (input tick, input restart, input run, input period,
                output expire);
endinterface

/* File: core/wdu_sync.sv */
// three-stage synchroniser with agree-on-two-stages edge output
`timescale 1ns/10ps
module wdu_sync
  import wdu_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // async input and rising-edge pulse
  input  wire logic async_in,
  output logic      rise
);
  logic [SYNC_DEPTH-1:0] stage;
  logic                  level;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage <= '0;
    end else begin
      stage <= {stage[SYNC_DEPTH-2:0], async_in};
    end
  end

  // level changes only once stages two and three agree
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (stage[1] == stage[2] && stage[2] != level) begin
        level <= stage[2];
        rise  <= stage[2];
      end
    end
  end
endmodule

/* File: core/wdu_counter.sv */
// watchdog down counter with selectable period
`timescale 1ns/10ps
module wdu_counter
  import wdu_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // control link
  wdu_tick_if.cnt   lnk
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] load_val;

  always_comb begin
    case (lnk.period)
      2'h0: load_val = PERIOD_00;
      2'h1: load_val = PERIOD_01;
      2'h2: load_val = PERIOD_10;
      default: load_val = PERIOD_11;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count      <= PERIOD_00;
      lnk.expire <= 1'b0;
    end else begin
      lnk.expire <= 1'b0;
      if (!lnk.run || lnk.restart) begin
        count <= load_val;
      end else if (lnk.tick) begin
        if (count == '0) begin
          count      <= load_val;
          lnk.expire <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

  a_expire_needs_run: assert property (
    @(posedge clock) disable iff (sys_rst)
    lnk.expire |-> $past(lnk.run) && $past(lnk.tick))
    else $error("expiry without running tick");
endmodule

/* File: core/wdu_top.sv */
// watchdog timeout unit with AXI4-Lite registers
// Notes on behaviour
// - watchdog starts disabled after any system reset.
// - once enabled, writes cannot clear the enable bit.
// - two-bit period field, bits one to zero, picks four lengths.
// - counter ticks on system clock or real-time clock source.
// - every timeout sets the cause flag.
// - timeout resets the cpu unless interrupt response selected.
// - timeout output changes only on rising clock edge.
// - with interrupt response selected, timeout raises nonmaskable interrupt.
// - keys a5 then 5a reload counter; any delay between them.
// - period codes 00,01,10,11 give 2^27,2^25,2^22,2^18 ticks.
// - clock select 00 system, 01 real-time; 10 and 11 reserved.
// - cause flag cleared only by a non-watchdog reset.
`timescale 1ns/10ps
module wdu_top
  import wdu_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // reset cause from reset controller: high when last reset was ours
  input  wire logic        wdog_caused_rst,
  // real-time clock source, asynchronous
  input  wire logic        rtc_src,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // toward the cpu
  output logic             cpu_reset_req,
  output logic             cpu_nmi,
  output logic             irq
);
  wdu_tick_if lnk ();

  logic       watchdog_enable_bit;
  logic       nmi_select;
  logic       cause_flag;
  logic [1:0] timer_clock_select;
  logic [1:0] timeout_period_select;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  wdu_key_t   key_state;
  logic       rtc_rise;
  logic       restart_done;

  // write channel capture
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic       w_lane0;
  logic       wr_fire;

  wdu_sync u_rtc_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (rtc_src),
    .rise     (rtc_rise)
  );

  wdu_counter u_counter (
    .clock   (clock),
    .sys_rst (sys_rst),
    .lnk     (lnk)
  );

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // axi write: address and data taken independently
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // unmapped writes are dropped and answered with slave error
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bresp <= (aw_addr == CTRL_ADDR || aw_addr == RESTART_ADDR ||
                      aw_addr == IRQ_STATUS_ADDR ||
                      aw_addr == IRQ_MASK_ADDR) ? 2'h0 : 2'h2;
    end
  end

  // control register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watchdog_enable_bit   <= CTRL_RESET[EN_BIT];
      nmi_select            <= CTRL_RESET[NMI_SEL_BIT];
      timer_clock_select    <= CTRL_RESET[CLK_SEL_LO +: 2];
      timeout_period_select <= CTRL_RESET[PERIOD_LO +: 2];
    end else if (wr_fire && w_lane0 && aw_addr == CTRL_ADDR) begin
      watchdog_enable_bit   <= watchdog_enable_bit | w_data[EN_BIT];
      nmi_select            <= w_data[NMI_SEL_BIT];
      timer_clock_select    <= w_data[CLK_SEL_LO +: 2];
      timeout_period_select <= w_data[PERIOD_LO +: 2];
    end
  end

  // cleared only by a reset not caused by the watchdog
  // set on every timeout; a non-watchdog reset clear wins over it, no software clear
  always_ff @(posedge clock) begin
    if (sys_rst && !wdog_caused_rst) begin
      cause_flag <= 1'b0;
    end else if (sys_rst) begin
      cause_flag <= 1'b1;
    end else if (lnk.expire) begin
      cause_flag <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      key_state    <= wdu_key_idle;
      restart_done <= 1'b0;
    end else begin
      restart_done <= 1'b0;
      if (wr_fire && w_lane0 && aw_addr == RESTART_ADDR) begin
        case (key_state)
          wdu_key_idle: begin
            if (w_data[7:0] == KEY_FIRST) begin
              key_state <= wdu_key_armed;
            end
          end
          wdu_key_armed: begin
            if (w_data[7:0] == KEY_SECOND) begin
              key_state    <= wdu_key_idle;
              restart_done <= 1'b1;
            end else if (w_data[7:0] != KEY_FIRST) begin
              key_state <= wdu_key_idle;
            end
          end
          default: key_state <= wdu_key_idle;
        endcase
      end
    end
  end

  // tick source; reserved codes stop the count
  always_comb begin
    case (timer_clock_select)
      CLK_SYS: lnk.tick = 1'b1;
      CLK_RTC: lnk.tick = rtc_rise;
      default: lnk.tick = 1'b0;
    endcase
  end
  assign lnk.run     = watchdog_enable_bit;
  assign lnk.restart = restart_done;
  assign lnk.period  = timeout_period_select;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cpu_reset_req <= 1'b0;
      cpu_nmi       <= 1'b0;
    end else begin
      cpu_reset_req <= lnk.expire && !nmi_select;
      cpu_nmi       <= lnk.expire && nmi_select;
    end
  end

  // sticky events; a read of status clears, events win over the clear
  logic st_rd;
  assign st_rd = s_axi_arvalid && s_axi_arready &&
                 s_axi_araddr == IRQ_STATUS_ADDR;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (st_rd ? 2'h0 : irq_status) |
                    {restart_done, lnk.expire};
      if (wr_fire && w_lane0 && aw_addr == IRQ_MASK_ADDR) begin
        irq_mask <= w_data[1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // axi read, one cycle latency
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        case (s_axi_araddr)
          CTRL_ADDR: s_axi_rdata <= {24'h000000, watchdog_enable_bit,
              nmi_select, cause_flag, timer_clock_select, 1'b0,
              timeout_period_select};
          IRQ_STATUS_ADDR: s_axi_rdata <= {30'h0, irq_status};
          IRQ_MASK_ADDR:   s_axi_rdata <= {30'h0, irq_mask};
          RESTART_ADDR:    s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  a_enable_sticky: assert property (
    @(posedge clock) disable iff (sys_rst)
    watchdog_enable_bit |=> watchdog_enable_bit)
    else $error("enable bit cleared without reset");
  a_reset_resp: assert property (
    @(posedge clock) disable iff (sys_rst)
    lnk.expire && !nmi_select |=> cpu_reset_req && !cpu_nmi)
    else $error("reset response missing");
  a_nmi_resp: assert property (
    @(posedge clock) disable iff (sys_rst)
    lnk.expire && nmi_select |=> cpu_nmi && !cpu_reset_req)
    else $error("nmi response missing");
  a_cause_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    lnk.expire |=> cause_flag)
    else $error("cause flag not set on timeout");
  a_cause_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    cause_flag |=> cause_flag)
    else $error("cause flag cleared without reset");
  a_no_run_off: assert property (
    @(posedge clock) disable iff (sys_rst)
    !watchdog_enable_bit |-> ##1 !cpu_reset_req && !cpu_nmi)
    else $error("timeout while disabled");
  a_key_restart: assert property (
    @(posedge clock) disable iff (sys_rst)
    restart_done |-> $past(key_state) == wdu_key_armed)
    else $error("restart without first key");
  a_rsvd_clock: assert property (
    @(posedge clock) disable iff (sys_rst)
    timer_clock_select[1] |-> !lnk.tick)
    else $error("reserved clock select ticks");
  a_pulse_out: assert property (
    @(posedge clock) disable iff (sys_rst)
    cpu_nmi |=> !cpu_nmi)
    else $error("nmi longer than one cycle");

  c_enable: cover property (@(posedge clock) $rose(watchdog_enable_bit));
  c_restart: cover property (@(posedge clock) restart_done);
  c_nmi: cover property (@(posedge clock) cpu_nmi);
  c_reset: cover property (@(posedge clock) cpu_reset_req);
endmodule

/* File: tb/wdu_cpu_model.sv */
// cpu reset partner: turns watchdog reset requests into system resets
`timescale 1ns/10ps
module wdu_cpu_model (
  // clock
  input  wire logic clock,
  // from the watchdog
  input  wire logic cpu_reset_req,
  input  wire logic cpu_nmi,
  // power-on request from the bench
  input  wire logic por_req,
  // reset toward the watchdog, and nmi seen flag for the bench
  output logic      sys_rst,
  output logic      wdog_caused_rst,
  output logic      nmi_seen
);
  logic [4:0] hold  = 5'h0c;
  logic       cause = 1'b0;
  always @(posedge clock) begin
    if (por_req) begin
      hold  <= 5'h0c;
      cause <= 1'b0;
    end else if (cpu_reset_req) begin
      hold  <= 5'h04;
      cause <= 1'b1;
    end else if (hold != 5'h00) begin
      hold <= hold - 5'h01;
    end
  end
  always @(posedge clock) begin
    // cleared during any reset not caused by the watchdog
    if (por_req || (hold != 5'h00 && !cause)) begin
      nmi_seen <= 1'b0;
    end else if (cpu_nmi) begin
      nmi_seen <= 1'b1;
    end
  end
  assign sys_rst         = (hold != 5'h00);
  assign wdog_caused_rst = cause;
endmodule

/* File: tb/tb_watchdog_timeout_unit.sv */
// self-checking bench for the watchdog timeout unit
`timescale 1ns/10ps
module tb_watchdog_timeout_unit;
  import wdu_pkg::*;
  localparam int TMO   = 2**18;
  localparam int LIMIT = 300000;
  logic        clock = 1'b0;
  logic        sys_rst, wdog_caused_rst, nmi_seen;
  logic        por_req = 1'b0;
  logic        rtc_src = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        cpu_reset_req, cpu_nmi, irq;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;

  wdu_top dut (.clock, .sys_rst, .wdog_caused_rst, .rtc_src,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .cpu_reset_req, .cpu_nmi, .irq);
  wdu_cpu_model cpu (.clock, .cpu_reset_req, .cpu_nmi, .por_req,
    .sys_rst, .wdog_caused_rst, .nmi_seen);

  always #12.5 clock = ~clock;

  // slow real-time source; also the hang limit
  always @(posedge clock) begin
    cyc++;
    rtc_src <= cyc[3];
    if (cyc == LIMIT) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, exp, input string s);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string s);
    chk_word({31'h0, got}, {31'h0, exp}, s);
  endtask

  // write address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit fin;
    fin = 0;
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    while (!fin) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        fin = 1;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit fin;
    fin = 0;
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    while (!fin) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        fin = 1;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] r;
    axi_wr(a, {24'h0, v}, r);
    chk_word({30'h0, r}, 32'h0, "write response");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_word({30'h0, r}, 32'h0, "read response");
    chk_word(d, {24'h0, v}, "register value");
  endtask

  task automatic wait_reset_done;
    while (sys_rst !== 1'b1) @(posedge clock);
    while (sys_rst === 1'b1) @(posedge clock);
  endtask

  task automatic t_after_reset;
    rd_chk(CTRL_ADDR, CTRL_RESET);
    chk_bit(cpu_reset_req, 1'b0, "reset request idle");
    chk_bit(cpu_nmi, 1'b0, "nmi idle");
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h10, 32'hff, r);
    chk_word({30'h0, r}, 32'h2, "unmapped write");
    axi_rd(8'h10, d, r);
    chk_word({d[29:0], r}, 32'h2, "unmapped read");
    rd_chk(RESTART_ADDR, 8'h00);
  endtask

  task automatic t_control;
    wr(CTRL_ADDR, 8'h03);
    rd_chk(CTRL_ADDR, 8'h03);
    wr(CTRL_ADDR, 8'h83);
    wr(CTRL_ADDR, 8'h4b);
    rd_chk(CTRL_ADDR, 8'hcb);
    wr(CTRL_ADDR, 8'h13);
    rd_chk(CTRL_ADDR, 8'h93);
    wr(CTRL_ADDR, 8'h03);
    rd_chk(CTRL_ADDR, 8'h83);
  endtask

  task automatic t_keys;
    wr(RESTART_ADDR, KEY_FIRST);
    repeat (50) @(posedge clock);
    wr(RESTART_ADDR, KEY_SECOND);
    rd_chk(IRQ_STATUS_ADDR, 8'h02);
    rd_chk(IRQ_STATUS_ADDR, 8'h00);
    wr(RESTART_ADDR, KEY_FIRST);
    wr(RESTART_ADDR, 8'h12);
    wr(RESTART_ADDR, KEY_SECOND);
    rd_chk(IRQ_STATUS_ADDR, 8'h00);
    wr(RESTART_ADDR, KEY_FIRST);
    wr(RESTART_ADDR, KEY_FIRST);
    wr(RESTART_ADDR, KEY_SECOND);
    rd_chk(IRQ_STATUS_ADDR, 8'h02);
  endtask

  // a mask bit of one lets its status bit through to irq
  task automatic t_irq;
    logic ia, ib;
    wr(RESTART_ADDR, KEY_FIRST);
    wr(RESTART_ADDR, KEY_SECOND);
    wr(IRQ_MASK_ADDR, 8'h00);
    repeat (3) @(posedge clock);
    ia = irq;
    wr(IRQ_MASK_ADDR, 8'h03);
    repeat (3) @(posedge clock);
    ib = irq;
    chk_bit(ia, 1'b0, "masked irq");
    chk_bit(ib, 1'b1, "unmasked irq");
    repeat (3) @(posedge clock);
    chk_bit(irq, 1'b1, "irq raised");
    rd_chk(IRQ_STATUS_ADDR, 8'h02);
    repeat (3) @(posedge clock);
    chk_bit(irq, 1'b0, "irq cleared");
  endtask

  task automatic t_timeout;
    logic [1:0] r;
    int         n;
    bit         early_nmi;
    n = 0;
    early_nmi = 0;
    wr(RESTART_ADDR, KEY_FIRST);
    axi_wr(RESTART_ADDR, {24'h0, KEY_SECOND}, r);
    while (cpu_reset_req !== 1'b1) begin
      @(posedge clock);
      n++;
      if (cpu_nmi === 1'b1) early_nmi = 1;
    end
    chk_bit(n >= TMO - 8 && n <= TMO + 8, 1'b1, "timeout length");
    chk_bit(early_nmi, 1'b0, "no nmi in reset mode");
    wait_reset_done();
    rd_chk(CTRL_ADDR, 8'h20);
    chk_bit(nmi_seen, 1'b0, "no nmi at all");
  endtask

  task automatic t_power_on;
    @(posedge clock);
    por_req <= 1'b1;
    @(posedge clock);
    por_req <= 1'b0;
    wait_reset_done();
    rd_chk(CTRL_ADDR, 8'h00);
  endtask

  initial begin
    while (sys_rst !== 1'b0) @(posedge clock);
    t_after_reset();
    t_unmapped();
    t_control();
    t_keys();
    t_irq();
    t_timeout();
    t_power_on();
    conclude();
  end
endmodule
